// [phgpio_clkmon.sv]
// clock monitor source select with registered output
`timescale 1ns/10ps
module phgpio_clkmon (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // select and sampled source levels
  input  wire logic [2:0] sel,
  input  wire logic [5:0] src,
  // monitor level
  output logic            mon
);
  phgpio_pkg::phgpio_mon_s s_reg;
  phgpio_pkg::phgpio_mon_s s_next;

  // sources are sampled levels, so the monitor only shows activity
  // and rough frequency well below half of hclk
  always_comb begin
    s_next = s_reg;
    if (sel < 3'h6) begin
      s_next.mon = src[sel];
    end else begin
      s_next.mon = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{mon: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign mon = s_reg.mon;
endmodule : phgpio_clkmon

// [phgpio_map.svh]
// register map, reset values, field positions and pin function masks
`ifndef PHGPIO_MAP_SVH
`define PHGPIO_MAP_SVH
// ============================================================
// byte addresses
`define PHGPIO_ADDR_PIN_SELECT    32'h5600_0070
`define PHGPIO_ADDR_PIN_DATA      32'h5600_0074
`define PHGPIO_ADDR_PULLUP_DIS    32'h5600_0078
`define PHGPIO_ADDR_RESERVED      32'h5600_007c
`define PHGPIO_ADDR_MISC          32'h5600_0080
// ============================================================
// reset values
`define PHGPIO_RST_PIN_SELECT     22'h00_0000
`define PHGPIO_RST_PIN_DATA       11'h000
`define PHGPIO_RST_PULLUP_DIS     11'h000
`define PHGPIO_RST_MISC           32'h0001_0330
// writable bits of the misc register, reserved bits read zero
`define PHGPIO_MISC_WMASK         32'h000f_377f
// ============================================================
// misc register fields
`define PHGPIO_MISC_CKE_LOW       19
`define PHGPIO_MISC_SCLK1_LOW     18
`define PHGPIO_MISC_SCLK0_LOW     17
`define PHGPIO_MISC_RESET_OUT     16
`define PHGPIO_MISC_USB1_SUSP     13
`define PHGPIO_MISC_USB0_SUSP     12
`define PHGPIO_MISC_MON1_SEL_LSB  8
`define PHGPIO_MISC_MON0_SEL_LSB  4
`define PHGPIO_MISC_USB_PAD_HOST  3
`define PHGPIO_MISC_MEM_HOLD      2
`define PHGPIO_MISC_DLO_PU_DIS    1
`define PHGPIO_MISC_DHI_PU_DIS    0
// ============================================================
// pin function masks: 1 = the function drives the pin; in the valid mask, 1 = the pin has a secondary function
`define PHGPIO_PRI_OUT_MASK       11'h656
`define PHGPIO_SEC_OUT_MASK       11'h040
`define PHGPIO_SEC_VALID_MASK     11'h0c0
`endif

// [phgpio_pads.sv]
// board side of the port h pins: drivers, pull-ups and floating pins
`timescale 1ns/10ps
module phgpio_pads (
  // clock
  input  wire logic        hclk,
  // block side
  input  wire logic [10:0] pin_out,
  input  wire logic [10:0] pin_oe_n,
  input  wire logic [10:0] pin_pullup_en,
  // board side
  input  wire logic [10:0] ext_level,
  input  wire logic [10:0] ext_drive,
  output logic      [10:0] pin_in
);
  // a floating pin toggles so a stale level can never pass for data
  logic [10:0] float_reg = 11'h555;
  always_ff @(posedge hclk) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_drive[i]) pin_in[i] = ext_level[i];
      else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule : phgpio_pads

// [phgpio_pin.sv]
// one port pin: output mux, drive enable, pull-up and input sample
`timescale 1ns/10ps
module phgpio_pin (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // configuration
  input  wire logic [1:0] mode,
  input  wire logic       data_out,
  input  wire logic       pullup_dis,
  // function side
  input  wire logic       pri_out,
  input  wire logic       sec_out,
  input  wire logic       pri_drives,
  input  wire logic       sec_drives,
  // pad
  input  wire logic       pin_in,
  output logic            pad_out,
  output logic            pad_oe_n,
  output logic            pad_pullup_en,
  output logic            level
);
  phgpio_pkg::phgpio_pin_s s_reg;
  phgpio_pkg::phgpio_pin_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.level = pin_in;
    s_next.pad_pullup_en = ~pullup_dis;
    s_next.pad_out = 1'b0;
    s_next.pad_oe_n = 1'b1;
    unique case (phgpio_pkg::phgpio_mode_e'(mode))
      phgpio_pkg::PHGPIO_MODE_INPUT: begin
        s_next.pad_oe_n = 1'b1;
      end
      phgpio_pkg::PHGPIO_MODE_OUTPUT: begin
        s_next.pad_out = data_out;
        s_next.pad_oe_n = 1'b0;
      end
      phgpio_pkg::PHGPIO_MODE_PRI: begin
        s_next.pad_out = pri_out;
        s_next.pad_oe_n = ~pri_drives;
      end
      phgpio_pkg::PHGPIO_MODE_SEC: begin
        // a reserved secondary code leaves the pin undriven
        s_next.pad_out = sec_out;
        s_next.pad_oe_n = ~sec_drives;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{pad_out: 1'b0, pad_oe_n: 1'b1,
                 pad_pullup_en: 1'b1, level: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pad_out       = s_reg.pad_out;
  assign pad_oe_n      = s_reg.pad_oe_n;
  assign pad_pullup_en = s_reg.pad_pullup_en;
  assign level         = s_reg.level;
endmodule : phgpio_pin

// [phgpio_pkg.sv]
// types shared by the port h and misc control block
package phgpio_pkg;
  // ============================================================
  // pin select codes
  typedef enum logic [1:0] {
    PHGPIO_MODE_INPUT  = 2'h0,
    PHGPIO_MODE_OUTPUT = 2'h1,
    PHGPIO_MODE_PRI    = 2'h2,
    PHGPIO_MODE_SEC    = 2'h3
  } phgpio_mode_e;
  // ============================================================
  // register slot of the current data phase
  typedef enum logic [2:0] {
    PHGPIO_IDX_SELECT = 3'h0,
    PHGPIO_IDX_DATA   = 3'h1,
    PHGPIO_IDX_PUD    = 3'h2,
    PHGPIO_IDX_RSVD   = 3'h3,
    PHGPIO_IDX_MISC   = 3'h4,
    PHGPIO_IDX_NONE   = 3'h7
  } phgpio_idx_e;
  // ============================================================
  // state of one pin cell
  typedef struct packed {
    logic pad_out;
    logic pad_oe_n;
    logic pad_pullup_en;
    logic level;
  } phgpio_pin_s;
  // state of one clock monitor
  typedef struct packed {
    logic mon;
  } phgpio_mon_s;
endpackage : phgpio_pkg

// [phgpio_top.sv]
// port h pin control and misc pad/clock control behind an ahb-lite slave
`timescale 1ns/10ps
`include "phgpio_map.svh"

// Notes on behaviour
// - two select bits per pin choose mode
// - input pins read back their pin level
// - output pins drive the written data bit
// - function pins read an undefined value
// - per-pin pull-up disable, zero enables pull-up
// - select and pull-up disable reset to zero
// - bit 19 forces sdram clock enable low
// - bits 18, 17 force sdram clocks low
// - bit 16 level drives reset output pin
// - bits 13, 12 suspend usb ports
// - bits 10:8 pick monitor one source
// - bits 6:4 pick monitor zero source
// - bit 3 gives usb pads to host
// - bit 2 chooses memory bus power-off state
// - bits 1, 0 disable data bus pull-ups
module phgpio_top #(
  parameter int NUM_PINS = 11
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [2:0]  hburst,
  input  wire logic [3:0]  hprot,
  input  wire logic        hmastlock,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // port pads
  input  wire logic [10:0] pin_in,
  output logic [10:0]      pin_out,
  output logic [10:0]      pin_oe_n,
  output logic [10:0]      pin_pullup_en,
  // serial channels, function side
  input  wire logic        serial0_request_to_send_n,
  input  wire logic        serial0_transmit,
  input  wire logic        serial1_transmit,
  input  wire logic        serial1_request_to_send_n,
  input  wire logic        serial2_transmit,
  output logic             serial0_clear_to_send_n,
  output logic             serial0_receive,
  output logic             serial1_receive,
  output logic             serial1_clear_to_send_n,
  output logic             serial2_receive,
  output logic             usb_clock_input,
  // sampled clock levels for the monitors
  input  wire logic        main_pll,
  input  wire logic        usb_pll,
  input  wire logic        core_clock,
  input  wire logic        bus_clock,
  input  wire logic        periph_clock,
  input  wire logic        divided_clock_0,
  input  wire logic        divided_clock_1,
  // sdram and memory bus pad control
  input  wire logic        sdram_cke_normal,
  input  wire logic        clock_gating_poweroff,
  output logic             sdram_clock_enable_out,
  output logic             sdram_clock0_force_low,
  output logic             sdram_clock1_force_low,
  output logic             memory_bus_hiz,
  output logic             memory_bus_hold,
  // reset output and usb pads
  output logic             reset_out_n,
  output logic             usb_port0_suspend,
  output logic             usb_port1_suspend,
  output logic             usb_pad_owner_select,
  // data bus pull-ups
  output logic             data_low_pullup_en,
  output logic             data_high_pullup_en
);
  // ============================================================
  // elaboration check
  // map fixed to eleven pins
  if (NUM_PINS != 11) begin : g_bad_pins
    $error("phgpio_top: the pin function map serves eleven pins only");
  end

  // ============================================================
  // state
  // all flops in one struct
  typedef struct packed {
    // software registers
    logic [21:0] sel;
    logic [10:0] data;
    logic [10:0] pud;
    logic [31:0] misc;

    // bus data phase
    logic        ph_wr;
    logic [2:0]  ph_idx;
    logic [31:0] rdata;
    logic        readyout;

    // pad control and function input levels
    logic        cke;
    logic        hiz;
    logic        hold;
    logic [5:0]  fin;
  } phgpio_top_s;

  phgpio_top_s s_reg;
  phgpio_top_s s_next;

  localparam phgpio_top_s RESET_STATE = '{
    sel:      `PHGPIO_RST_PIN_SELECT,
    data:     `PHGPIO_RST_PIN_DATA,
    pud:      `PHGPIO_RST_PULLUP_DIS,
    misc:     `PHGPIO_RST_MISC,
    ph_wr:    1'b0,
    ph_idx:   3'h7,
    rdata:    32'h0000_0000,
    readyout: 1'b1,
    cke:      1'b0,
    hiz:      1'b0,
    hold:     1'b0,
    // usb clock rests low
    fin:      6'h1f
  };

  // ============================================================
  // pin cells
  logic [10:0] pri_out;
  logic [10:0] sec_out;
  logic [10:0] level;
  logic [10:0] data_rd;
  logic        mon0;
  logic        mon1;

  // 0: input-only function
  assign pri_out = {mon1, mon0, 1'b0, 1'b0, serial2_transmit, 1'b0,
                    serial1_transmit, 1'b0, serial0_transmit,
                    serial0_request_to_send_n, 1'b0};
  assign sec_out = {4'h0, serial1_request_to_send_n, 6'h00};

  localparam logic [10:0] PRI_OUT = `PHGPIO_PRI_OUT_MASK;
  localparam logic [10:0] SEC_OUT = `PHGPIO_SEC_OUT_MASK;

  // one cell per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    phgpio_pin u_pin (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .mode          (s_reg.sel[2*i +: 2]),
      .data_out      (s_reg.data[i]),
      .pullup_dis    (s_reg.pud[i]),
      .pri_out       (pri_out[i]),
      .sec_out       (sec_out[i]),
      .pri_drives    (PRI_OUT[i]),
      .sec_drives    (SEC_OUT[i]),
      .pin_in        (pin_in[i]),
      .pad_out       (pin_out[i]),
      .pad_oe_n      (pin_oe_n[i]),
      .pad_pullup_en (pin_pullup_en[i]),
      .level         (level[i])
    );
    // function pins read zero; software must not rely on it
    assign data_rd[i] =
      (s_reg.sel[2*i +: 2] == 2'h0) ? level[i] :
      (s_reg.sel[2*i +: 2] == 2'h1) ? s_reg.data[i] :
      1'b0;
  end

  // ============================================================
  // clock monitors
  // sources by select code
  phgpio_clkmon u_mon0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sel     (s_reg.misc[`PHGPIO_MISC_MON0_SEL_LSB +: 3]),
    .src     ({divided_clock_0, periph_clock, bus_clock,
               core_clock, usb_pll, main_pll}),
    .mon     (mon0)
  );

  // same map, other divided clock
  phgpio_clkmon u_mon1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sel     (s_reg.misc[`PHGPIO_MISC_MON1_SEL_LSB +: 3]),
    .src     ({divided_clock_1, periph_clock, bus_clock,
               core_clock, usb_pll, main_pll}),
    .mon     (mon1)
  );

  // ============================================================
  // address decode
  logic        take;
  logic [2:0]  idx;

  // idle and busy are ignored
  assign take = hsel & hready & htrans[1];

  // full decode: aliases read 0
  always_comb begin
    unique case (haddr)
      `PHGPIO_ADDR_PIN_SELECT: idx = phgpio_pkg::PHGPIO_IDX_SELECT;
      `PHGPIO_ADDR_PIN_DATA:   idx = phgpio_pkg::PHGPIO_IDX_DATA;
      `PHGPIO_ADDR_PULLUP_DIS: idx = phgpio_pkg::PHGPIO_IDX_PUD;
      `PHGPIO_ADDR_RESERVED:   idx = phgpio_pkg::PHGPIO_IDX_RSVD;
      `PHGPIO_ADDR_MISC:       idx = phgpio_pkg::PHGPIO_IDX_MISC;
      default:                 idx = phgpio_pkg::PHGPIO_IDX_NONE;
    endcase
  end

  // ============================================================
  // next state
  localparam logic [31:0] MISC_WMASK = `PHGPIO_MISC_WMASK;

  always_comb begin
    s_next = s_reg;
    // no wait states
    s_next.readyout = 1'b1;

    // data phase write; the read below sees the new select, pull-up disable
    // and misc values, but a pin data read still uses the old data and select
    if (s_reg.ph_wr) begin
      unique case (s_reg.ph_idx)
        phgpio_pkg::PHGPIO_IDX_SELECT: begin
          s_next.sel = hwdata[21:0];
        end
        phgpio_pkg::PHGPIO_IDX_DATA: begin
          s_next.data = hwdata[10:0];
        end
        phgpio_pkg::PHGPIO_IDX_PUD: begin
          s_next.pud = hwdata[10:0];
        end
        phgpio_pkg::PHGPIO_IDX_MISC: begin
          s_next.misc = hwdata & MISC_WMASK;
        end
        default: begin
          s_next.misc = s_reg.misc;
        end
      endcase
    end

    // address phase; read data stand
    // until the next read
    s_next.ph_wr = take & hwrite;
    s_next.ph_idx = take ? idx : 3'h7;
    if (take & ~hwrite) begin
      unique case (idx)
        phgpio_pkg::PHGPIO_IDX_SELECT: begin
          s_next.rdata = {10'h000, s_next.sel};
        end
        phgpio_pkg::PHGPIO_IDX_DATA: begin
          s_next.rdata = {21'h00_0000, data_rd};
        end
        phgpio_pkg::PHGPIO_IDX_PUD: begin
          s_next.rdata = {21'h00_0000, s_next.pud};
        end
        phgpio_pkg::PHGPIO_IDX_MISC: begin
          s_next.rdata = s_next.misc;
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // pad and clock control levels
    s_next.cke = sdram_cke_normal &
                 ~s_reg.misc[`PHGPIO_MISC_CKE_LOW];

    // the hold choice only matters while power-off is active
    s_next.hiz = clock_gating_poweroff &
                 ~s_reg.misc[`PHGPIO_MISC_MEM_HOLD];
    s_next.hold = clock_gating_poweroff &
                  s_reg.misc[`PHGPIO_MISC_MEM_HOLD];

    // function inputs toward peripherals; serial inputs idle high when not routed
    s_next.fin[0] = (s_reg.sel[1:0] == 2'h2) ? level[0] : 1'b1;
    s_next.fin[1] = (s_reg.sel[7:6] == 2'h2) ? level[3] : 1'b1;
    s_next.fin[2] = (s_reg.sel[11:10] == 2'h2) ? level[5] : 1'b1;

    // pin 7: one of two inputs
    s_next.fin[3] = (s_reg.sel[15:14] == 2'h3) ? level[7] : 1'b1;
    s_next.fin[4] = (s_reg.sel[15:14] == 2'h2) ? level[7] : 1'b1;

    // idle clock input low
    s_next.fin[5] = (s_reg.sel[17:16] == 2'h2) ? level[8] : 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ============================================================
  // outputs
  // bus answer
  assign hreadyout = s_reg.readyout;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;

  // peripheral inputs
  assign serial0_clear_to_send_n = s_reg.fin[0];
  assign serial0_receive         = s_reg.fin[1];
  assign serial1_receive         = s_reg.fin[2];
  assign serial1_clear_to_send_n = s_reg.fin[3];
  assign serial2_receive         = s_reg.fin[4];
  assign usb_clock_input         = s_reg.fin[5];

  // sdram and memory bus
  assign sdram_clock_enable_out = s_reg.cke;
  assign sdram_clock0_force_low =
    s_reg.misc[`PHGPIO_MISC_SCLK0_LOW];
  assign sdram_clock1_force_low =
    s_reg.misc[`PHGPIO_MISC_SCLK1_LOW];
  assign memory_bus_hiz  = s_reg.hiz;
  assign memory_bus_hold = s_reg.hold;

  // reset out and usb
  assign reset_out_n = s_reg.misc[`PHGPIO_MISC_RESET_OUT];
  assign usb_port0_suspend =
    s_reg.misc[`PHGPIO_MISC_USB0_SUSP];
  assign usb_port1_suspend =
    s_reg.misc[`PHGPIO_MISC_USB1_SUSP];
  assign usb_pad_owner_select =
    s_reg.misc[`PHGPIO_MISC_USB_PAD_HOST];

  // data bus pull-ups
  assign data_low_pullup_en =
    ~s_reg.misc[`PHGPIO_MISC_DLO_PU_DIS];
  assign data_high_pullup_en =
    ~s_reg.misc[`PHGPIO_MISC_DHI_PU_DIS];
endmodule : phgpio_top

// [phgpio_top_asserts.sv]
// bus, pad and misc output checks for the port h block
`timescale 1ns/10ps
module phgpio_top_asserts #(
  parameter int NUM_PINS = 11
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // pads and outputs
  input wire logic [10:0] pin_in,
  input wire logic [10:0] pin_pullup_en,
  input wire logic        usb_clock_input,
  input wire logic        sdram_cke_normal,
  input wire logic        clock_gating_poweroff,
  input wire logic        sdram_clock_enable_out,
  input wire logic        sdram_clock0_force_low,
  input wire logic        sdram_clock1_force_low,
  input wire logic        memory_bus_hiz,
  input wire logic        memory_bus_hold,
  input wire logic        reset_out_n,
  input wire logic        usb_port0_suspend,
  input wire logic        usb_port1_suspend,
  input wire logic        usb_pad_owner_select,
  input wire logic        data_low_pullup_en,
  input wire logic        data_high_pullup_en
);
  // ============================================================
  // helpers
  logic take;
  logic wr;
  logic [7:0] misc_q;
  assign take = hsel && hready && htrans[1];
  assign wr = take && hwrite;
  assign misc_q = {reset_out_n, usb_port0_suspend, usb_port1_suspend,
                   usb_pad_owner_select, data_low_pullup_en,
                   data_high_pullup_en, sdram_clock0_force_low,
                   sdram_clock1_force_low};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ============================================================
  // assertions
  bus_ready_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  bus_okay_a: assert property (!hresp)
    else $error("slave answered with an error");
  rdata_hold_a: assert property (!$stable(hrdata) |-> $past(take && !hwrite))
    else $error("read data moved without a read");
  misc_write_a: assert property (
    !$stable(misc_q) |-> $past(wr, 2) || $past(wr, 3))
    else $error("misc output moved without a write");
  pullup_write_a: assert property (
    !$stable(pin_pullup_en) |-> $past(wr, 2) || $past(wr, 3))
    else $error("pull-up enable moved without a write");
  cke_gate_a: assert property (
    sdram_clock_enable_out |-> $past(sdram_cke_normal))
    else $error("clock enable high without normal enable");
  mem_off_a: assert property (
    $past(clock_gating_poweroff) && $past(hresetn)
    |-> memory_bus_hiz ^ memory_bus_hold)
    else $error("power-off bus state not exactly one of hiz/hold");
  mem_on_a: assert property (
    !$past(clock_gating_poweroff) |-> !memory_bus_hiz && !memory_bus_hold)
    else $error("bus state forced outside power-off");
  usb_clk_a: assert property (
    usb_clock_input |-> $past(pin_in[8]) || $past(pin_in[8], 2))
    else $error("usb clock input high without pin level");
endmodule : phgpio_top_asserts

bind phgpio_top phgpio_top_asserts #(.NUM_PINS(NUM_PINS)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
  .pin_pullup_en(pin_pullup_en), .usb_clock_input(usb_clock_input),
  .sdram_cke_normal(sdram_cke_normal),
  .clock_gating_poweroff(clock_gating_poweroff),
  .sdram_clock_enable_out(sdram_clock_enable_out),
  .sdram_clock0_force_low(sdram_clock0_force_low),
  .sdram_clock1_force_low(sdram_clock1_force_low),
  .memory_bus_hiz(memory_bus_hiz), .memory_bus_hold(memory_bus_hold),
  .reset_out_n(reset_out_n), .usb_port0_suspend(usb_port0_suspend),
  .usb_port1_suspend(usb_port1_suspend),
  .usb_pad_owner_select(usb_pad_owner_select),
  .data_low_pullup_en(data_low_pullup_en),
  .data_high_pullup_en(data_high_pullup_en)
);

// [testbench.sv]
// self-checking bench for the port h and misc control block
`timescale 1ns/10ps
`include "phgpio_map.svh"
module testbench;
  // ============================================================
  // stimulus and observed signals
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [10:0] ext_level = 11'h0;
  logic [10:0] ext_drive = 11'h0;
  logic [4:0]  fn_out = 5'h1f;
  logic [6:0]  src = 7'h0;
  logic        cke_normal = 1'b1;
  logic        poweroff = 1'b0;
  wire logic   hready;
  wire logic   hresp;
  wire logic [31:0] hrdata;
  wire logic [10:0] pin_in, pin_out, pin_oe_n, pin_pu, misc_out;
  wire logic [5:0]  fn_in;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  phgpio_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hburst(3'h0),
    .hprot(4'h3), .hmastlock(1'b0), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pu), .serial0_request_to_send_n(fn_out[0]),
    .serial0_transmit(fn_out[1]), .serial1_transmit(fn_out[2]),
    .serial1_request_to_send_n(fn_out[3]), .serial2_transmit(fn_out[4]),
    .serial0_clear_to_send_n(fn_in[0]), .serial0_receive(fn_in[1]),
    .serial1_receive(fn_in[2]), .serial1_clear_to_send_n(fn_in[3]),
    .serial2_receive(fn_in[4]), .usb_clock_input(fn_in[5]),
    .main_pll(src[0]), .usb_pll(src[1]), .core_clock(src[2]),
    .bus_clock(src[3]), .periph_clock(src[4]),
    .divided_clock_0(src[5]), .divided_clock_1(src[6]),
    .sdram_cke_normal(cke_normal), .clock_gating_poweroff(poweroff),
    .sdram_clock_enable_out(misc_out[10]),
    .sdram_clock1_force_low(misc_out[9]),
    .sdram_clock0_force_low(misc_out[8]), .reset_out_n(misc_out[7]),
    .usb_port1_suspend(misc_out[6]), .usb_port0_suspend(misc_out[5]),
    .usb_pad_owner_select(misc_out[4]), .memory_bus_hiz(misc_out[3]),
    .memory_bus_hold(misc_out[2]), .data_low_pullup_en(misc_out[1]),
    .data_high_pullup_en(misc_out[0]));
  phgpio_pads pads (
    .hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pu), .ext_level(ext_level),
    .ext_drive(ext_drive), .pin_in(pin_in));
  // ============================================================
  // clock, timeout, report
  initial forever #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // ============================================================
  // bus cycles: address phase held until ready, then data phase
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string what, input logic [31:0] a, exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask : rdc
  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask : settle
  // ============================================================
  // scenarios
  task automatic t_reset;
    rdc("select", `PHGPIO_ADDR_PIN_SELECT, 32'h0);
    rdc("pullup", `PHGPIO_ADDR_PULLUP_DIS, 32'h0);
    rdc("misc", `PHGPIO_ADDR_MISC, `PHGPIO_RST_MISC);
    chk("pin_pullup_en", 32'h7ff, pin_pu);
    chk("pin_oe_n", 32'h7ff, pin_oe_n);
    chk("misc outs", 32'h483, misc_out);
  endtask : t_reset
  task automatic t_gpio;
    wr(`PHGPIO_ADDR_PIN_SELECT, 32'h0015_5555);
    wr(`PHGPIO_ADDR_PIN_DATA, 32'h5a5);
    settle();
    chk("pin_out", 32'h5a5, pin_out);
    chk("pin_oe_n", 32'h0, pin_oe_n);
    rdc("data out", `PHGPIO_ADDR_PIN_DATA, 32'h5a5);
    wr(`PHGPIO_ADDR_PIN_SELECT, 32'h0);
    ext_drive <= 11'h7ff;
    ext_level <= 11'h3c3;
    settle();
    rdc("data in", `PHGPIO_ADDR_PIN_DATA, 32'h3c3);
    ext_drive <= 11'h0;
    settle();
    rdc("pulled", `PHGPIO_ADDR_PIN_DATA, 32'h7ff);
    wr(`PHGPIO_ADDR_PULLUP_DIS, 32'h7ff);
    settle();
    chk("pin_pullup_en", 32'h0, pin_pu);
    rdc("pullup", `PHGPIO_ADDR_PULLUP_DIS, 32'h7ff);
  endtask : t_gpio
  task automatic t_func;
    // every pin primary, pin 6 secondary
    wr(`PHGPIO_ADDR_PIN_SELECT, 32'h002a_baaa);
    for (int v = 0; v < 2; v++) begin
      fn_out <= {v[0], v[0], ~v[0], ~v[0], v[0]};
      ext_drive <= 11'h1a9;
      ext_level <= {2'b00, ~v[0], v[0], 1'b0, ~v[0], 1'b0, v[0], 2'b00,
                    v[0]};
      settle();
      chk("fn outs", {28'h0, ~v[0], ~v[0], v[0], v[0]},
          {pin_out[4], pin_out[2], pin_out[1], pin_out[6]});
      chk("fn ins", {26'h0, ~v[0], v[0], 1'b1, ~v[0], v[0], v[0]},
          fn_in);
      chk("fn oe_n", 32'h1a9, pin_oe_n);
    end
  endtask : t_func
  task automatic t_monitor;
    logic [6:0] one;
    // monitors are only looked at here, never used to clock anything
    for (int i = 0; i < 6; i++) begin
      one = (i == 5) ? 7'h60 : 7'h01 << i;
      src <= one;
      wr(`PHGPIO_ADDR_MISC, 32'h0001_0000 | (i << 8) | (i << 4));
      settle();
      chk("monitors hi", 32'h3, pin_out[10:9]);
      src <= ~one;
      settle();
      chk("monitors lo", 32'h0, pin_out[10:9]);
    end
  endtask : t_monitor
  task automatic t_misc;
    poweroff <= 1'b1;
    wr(`PHGPIO_ADDR_MISC, 32'hffff_ffff);
    settle();
    rdc("misc mask", `PHGPIO_ADDR_MISC, `PHGPIO_MISC_WMASK);
    chk("misc outs", 32'h3f4, misc_out);
    wr(`PHGPIO_ADDR_MISC, 32'h0);
    settle();
    chk("misc outs", 32'h40b, misc_out);
  endtask : t_misc
  task automatic t_reserved;
    wr(`PHGPIO_ADDR_RESERVED, 32'hffff_ffff);
    wr(32'h5600_0100, 32'hffff_ffff);
    rdc("reserved", `PHGPIO_ADDR_RESERVED, 32'h0);
    rdc("unmapped", 32'h5600_0100, 32'h0);
    rdc("select kept", `PHGPIO_ADDR_PIN_SELECT, 32'h002a_baaa);
  endtask : t_reserved
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_gpio();
    t_func();
    t_monitor();
    t_misc();
    t_reserved();
    close_out();
  end
endmodule : testbench
